// ### core/vocr_cfg.svh
`ifndef VOCR_CFG_SVH
`define VOCR_CFG_SVH
// Command codes
`define VOCR_CMD_OV_RESP 8'h41
`define VOCR_CMD_OV_WARN 8'h42
`define VOCR_CMD_UV_WARN 8'h43
// Response byte fields
`define VOCR_ACT_FLD 7:6
`define VOCR_RETRY_FLD 5:3
`define VOCR_DELAY_FLD 2:0
`define VOCR_ACT_IGNORE 2'h0
`define VOCR_ACT_BAD 2'h3
`define VOCR_RETRY_NONE 3'h0
`define VOCR_RETRY_FOREVER 3'h7
// Warning percentage windows
`define VOCR_OVW_PCT_MIN 24'h000067
`define VOCR_OVW_PCT_MAX 24'h000074
`define VOCR_UVW_PCT_MIN 24'h000054
`define VOCR_UVW_PCT_MAX 24'h000061
`define VOCR_PCT_SCALE 24'h000064
// Relative format: this code stands for 100 percent
`define VOCR_REL_UNITY 16'h0200
// Power-up contents standing in for the nonvolatile copy
`define VOCR_OV_RESP_RST 8'h80
`define VOCR_OV_WARN_RST 16'h0234
`define VOCR_UV_WARN_RST 16'h01CD
`define VOCR_OVW_PCT_RST 8'h6F
`define VOCR_UVW_PCT_RST 8'h5A
`endif

// ### core/vocr_pkg.sv
package vocr_pkg;
  // Command as handed over from the link side
  typedef struct packed {
    logic write;
    logic word;
    logic [7:0] code;
    logic [15:0] data;
  } vocr_cmd_s;

  // Sticky status flags seen by the host
  typedef struct packed {
    logic byte_ov;
    logic word_vout;
    logic vout_ovf;
    logic high_warn_limit_field;
    logic low_warn_limit_field;
    logic cml_data;
  } vocr_status_s;

  // Output control states
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ON = 2'b01,
    ST_BACKOFF = 2'b10,
    ST_LATCH = 2'b11
  } vocr_state_e;
endpackage

// ### core/vocr_core.sv
`timescale 1ns/1ps
`include "vocr_cfg.svh"
// Behaviour
// - OV fault sets status byte, word VOUT and VOUT OVF bits and alerts in the same cycle.
// - Action field 00 ignores, 01 and 10 shut down with restart, 11 invalid.
// - Restart field zero latches off after shutdown, no retry.
// - Restart field 1..6 retries that many times after backoff, then latches.
// - Restart field 7 retries forever until commanded off or start succeeds.
// - Delay field 0 waits one rise time, 1..7 wait that many rise times.
// - Start succeeds after one fault-free rise time; counter then clears.
// - Never start while an OV fault is present at enable, even when ignoring.
// - Invalid written values set the data status bit and alert the host.
// - Output above OV warning sets word VOUT and HIGH_WARN_LIMIT_FIELD bits, alerts.
// - OV warning kept as percentage of output target; stored word untouched.
// - OV warning maps to 103..116 percent in 1 percent steps, rounding up.
// - Both warning limits are 16-bit words, relative or absolute format.
// - While on, output below UV warning sets word VOUT and LOW_WARN_LIMIT_FIELD bits, alerts.
// - UV warning kept as percentage of output target; stored word untouched.
// - 41h is byte access, 42h and 43h word access, updated on the fly.
// - UV warning maps to 84..97 percent in 1 percent steps, rounding down.
module vocr_core (
  // Clocks and reset
  input wire logic core_clk_in,
  input wire logic lnk_clk_in,
  input wire logic rst_n_in,
  // Command link, link clock domain
  input wire logic lnk_req_in,
  input wire vocr_pkg::vocr_cmd_s lnk_cmd_in,
  output logic lnk_busy_out,
  output logic lnk_rsp_valid_out,
  output logic [15:0] lnk_rdata_out,
  // Power stage side
  input wire logic ov_fault_in,
  input wire logic enable_in,
  input wire logic [15:0] vout_sense_in,
  input wire logic [15:0] vout_cmd_in,
  input wire logic vout_rel_in,
  input wire logic [15:0] ton_rise_ticks_in,
  input wire logic ton_max_on_in,
  input wire logic rise_done_in,
  input wire logic ton_max_done_in,
  output logic conv_on_out,
  // Status and host notification
  input wire logic status_clr_in,
  output vocr_pkg::vocr_status_s status_out,
  output logic alert_n_out,
  output logic [7:0] ovw_pct_out,
  output logic [7:0] uvw_pct_out,
  output logic [2:0] restart_cnt_out
);
  // Limit to percentage, rounded up or down
  function automatic logic [23:0] pct_f(input logic [15:0] lim, input logic [15:0] rv,
                                         input logic up);
    logic [23:0] num;
    logic [23:0] q;
    num = 24'(lim) * `VOCR_PCT_SCALE;
    q = num / {8'h00, rv};
    if (up && (q * {8'h00, rv}) != num) begin
      q = q + 24'h000001;
    end
    return q;
  endfunction

  // Link side handshake
  vocr_pkg::vocr_cmd_s hold_q;
  logic req_tgl_q, busy_q, rsp_v_q;
  logic [15:0] lrd_q;
  logic ack_s1_q, ack_s2_q, ack_s3_q;
  logic ack_tgl_q;
  logic [15:0] rd_q;
  wire ack_edge = ack_s2_q ^ ack_s3_q;

  // Capture one command and hold it until answered
  always_ff @(posedge lnk_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_q <= '0;
      req_tgl_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (lnk_req_in && !busy_q) begin
      hold_q <= lnk_cmd_in;
      req_tgl_q <= ~req_tgl_q;
      busy_q <= 1'b1;
    end else if (ack_edge) begin
      busy_q <= 1'b0;
    end
  end

  // Answer toggle back into the link domain
  always_ff @(posedge lnk_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      rsp_v_q <= 1'b0;
      lrd_q <= 16'h0000;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      rsp_v_q <= ack_edge;
      if (ack_edge) begin
        lrd_q <= rd_q;
      end
    end
  end

  assign lnk_busy_out = busy_q;
  assign lnk_rsp_valid_out = rsp_v_q;
  assign lnk_rdata_out = lrd_q;

  // Core side synchronisers
  logic req_s1_q, req_s2_q, req_s3_q;
  logic ov_s1_q, ov_s, en_s1_q, en_s;
  wire req_edge = req_s2_q ^ req_s3_q;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ov_s1_q <= 1'b0;
      ov_s <= 1'b0;
      en_s1_q <= 1'b0;
      en_s <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      ov_s1_q <= ov_fault_in;
      ov_s <= ov_s1_q;
      en_s1_q <= enable_in;
      en_s <= en_s1_q;
    end
  end

  // Command registers
  logic [7:0] ov_resp_q;
  logic [15:0] ovw_q, uvw_q;
  logic [7:0] ovw_pct_q, uvw_pct_q;
  logic cmd_bad;
  logic [15:0] rd_d;
  wire [15:0] ref_v = vout_rel_in ? `VOCR_REL_UNITY : vout_cmd_in;
  wire [23:0] ovw_calc = pct_f(hold_q.data, ref_v, 1'b1);
  wire [23:0] uvw_calc = pct_f(hold_q.data, ref_v, 1'b0);
  wire ref_ok = (ref_v != 16'h0000);
  wire ovw_ok = ref_ok && ovw_calc >= `VOCR_OVW_PCT_MIN && ovw_calc <= `VOCR_OVW_PCT_MAX;
  wire uvw_ok = ref_ok && uvw_calc >= `VOCR_UVW_PCT_MIN && uvw_calc <= `VOCR_UVW_PCT_MAX;

  // Decode, read data and validity of the pending command
  always_comb begin
    cmd_bad = 1'b0;
    rd_d = 16'h0000;
    if (hold_q.code == `VOCR_CMD_OV_RESP) begin
      rd_d = {8'h00, ov_resp_q};
      cmd_bad = hold_q.word;
      if (hold_q.write && hold_q.data[`VOCR_ACT_FLD] == `VOCR_ACT_BAD) begin
        cmd_bad = 1'b1;
      end
    end else if (hold_q.code == `VOCR_CMD_OV_WARN) begin
      rd_d = ovw_q;
      cmd_bad = !hold_q.word || (hold_q.write && !ovw_ok);
    end else if (hold_q.code == `VOCR_CMD_UV_WARN) begin
      rd_d = uvw_q;
      cmd_bad = !hold_q.word || (hold_q.write && !uvw_ok);
    end else begin
      cmd_bad = 1'b1;
    end
  end

  // Accepted writes update limit and hardware percentage together
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ov_resp_q <= `VOCR_OV_RESP_RST;
      ovw_q <= `VOCR_OV_WARN_RST;
      uvw_q <= `VOCR_UV_WARN_RST;
      ovw_pct_q <= `VOCR_OVW_PCT_RST;
      uvw_pct_q <= `VOCR_UVW_PCT_RST;
    end else if (req_edge && hold_q.write && !cmd_bad) begin
      if (hold_q.code == `VOCR_CMD_OV_RESP) begin
        ov_resp_q <= hold_q.data[7:0];
      end else if (hold_q.code == `VOCR_CMD_OV_WARN) begin
        ovw_q <= hold_q.data;
        ovw_pct_q <= ovw_calc[7:0];
      end else begin
        uvw_q <= hold_q.data;
        uvw_pct_q <= uvw_calc[7:0];
      end
    end
  end

  // Answer back to the link, data held until the next command
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_tgl_q <= 1'b0;
      rd_q <= 16'h0000;
    end else if (req_edge) begin
      ack_tgl_q <= ~ack_tgl_q;
      rd_q <= hold_q.write ? 16'h0000 : rd_d;
    end
  end

  // Output control and restart policy
  vocr_pkg::vocr_state_e state_q, state_d;
  logic [2:0] cnt_q, per_q;
  logic [15:0] timer_q;
  logic attempt_q, win_act_q, shut;
  wire [1:0] act = ov_resp_q[`VOCR_ACT_FLD];
  wire [2:0] retry = ov_resp_q[`VOCR_RETRY_FLD];
  wire [2:0] delay = ov_resp_q[`VOCR_DELAY_FLD];
  wire [2:0] mult = (delay == 3'h0) ? 3'h1 : delay;
  wire tick_end = ({1'b0, timer_q} + 17'h00001) >= {1'b0, ton_rise_ticks_in};
  wire hic_end = tick_end && (per_q == mult - 3'h1);
  wire win_start = ton_max_on_in ? ton_max_done_in : rise_done_in;
  wire win_end = state_q == vocr_pkg::ST_ON && win_act_q && tick_end
                 && state_d == vocr_pkg::ST_ON;
  wire give_up = retry == `VOCR_RETRY_NONE
                 || (retry != `VOCR_RETRY_FOREVER && attempt_q
                     && ({1'b0, cnt_q} + 4'h1) >= {1'b0, retry});

  // Next state
  always_comb begin
    state_d = state_q;
    shut = 1'b0;
    case (state_q)
      vocr_pkg::ST_OFF: begin
        if (en_s && !ov_s) begin
          state_d = vocr_pkg::ST_ON;
        end
      end
      vocr_pkg::ST_ON: begin
        if (!en_s) begin
          state_d = vocr_pkg::ST_OFF;
        end else if (ov_s && act != `VOCR_ACT_IGNORE) begin
          shut = 1'b1;
          state_d = give_up ? vocr_pkg::ST_LATCH : vocr_pkg::ST_BACKOFF;
        end
      end
      vocr_pkg::ST_BACKOFF: begin
        if (!en_s) begin
          state_d = vocr_pkg::ST_OFF;
        end else if (hic_end && !ov_s) begin
          state_d = vocr_pkg::ST_ON;
        end
      end
      vocr_pkg::ST_LATCH: begin
        if (!en_s) begin
          state_d = vocr_pkg::ST_OFF;
        end
      end
      default: state_d = vocr_pkg::ST_OFF;
    endcase
  end

  // State and stage enable
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= vocr_pkg::ST_OFF;
      conv_on_out <= 1'b0;
    end else begin
      state_q <= state_d;
      conv_on_out <= (state_d == vocr_pkg::ST_ON);
    end
  end

  // Backoff and qualification timer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_q <= 16'h0000;
      per_q <= 3'h0;
      win_act_q <= 1'b0;
    end else if (state_q != state_d) begin
      timer_q <= 16'h0000;
      per_q <= 3'h0;
      win_act_q <= 1'b0;
    end else if (state_q == vocr_pkg::ST_BACKOFF) begin
      if (tick_end) begin
        timer_q <= 16'h0000;
        per_q <= per_q + 3'h1;
      end else begin
        timer_q <= timer_q + 16'h0001;
      end
    end else if (state_q == vocr_pkg::ST_ON) begin
      if (win_start) begin
        win_act_q <= 1'b1;
        timer_q <= 16'h0000;
      end else if (win_act_q) begin
        win_act_q <= !tick_end;
        timer_q <= timer_q + 16'h0001;
      end
    end
  end

  // Restart counter and pending attempt
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 3'h0;
      attempt_q <= 1'b0;
    end else if (!en_s) begin
      cnt_q <= 3'h0;
      attempt_q <= 1'b0;
    end else if (shut) begin
      if (attempt_q && cnt_q != 3'h7) begin
        cnt_q <= cnt_q + 3'h1;
      end
      attempt_q <= 1'b0;
    end else if (win_end) begin
      cnt_q <= 3'h0;
      attempt_q <= 1'b0;
    end else if (state_q == vocr_pkg::ST_BACKOFF && state_d == vocr_pkg::ST_ON) begin
      attempt_q <= 1'b1;
    end
  end

  // Warning comparisons against percentage of the output target
  wire [23:0] sense_x = 24'(vout_sense_in) * `VOCR_PCT_SCALE;
  wire ovw_hit = sense_x > 24'(vout_cmd_in) * 24'(ovw_pct_q);
  wire uvw_hit = state_q == vocr_pkg::ST_ON
                 && sense_x < 24'(vout_cmd_in) * 24'(uvw_pct_q);
  wire bad_set = req_edge && cmd_bad;
  vocr_pkg::vocr_status_s st_q;

  // Sticky flags, a set in the clear cycle wins
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q.byte_ov <= (st_q.byte_ov && !status_clr_in) || ov_s;
      st_q.vout_ovf <= (st_q.vout_ovf && !status_clr_in) || ov_s;
      st_q.high_warn_limit_field <= (st_q.high_warn_limit_field && !status_clr_in) || ovw_hit;
      st_q.low_warn_limit_field <= (st_q.low_warn_limit_field && !status_clr_in) || uvw_hit;
      st_q.word_vout <= (st_q.word_vout && !status_clr_in)
                        || ov_s || ovw_hit || uvw_hit;
      st_q.cml_data <= (st_q.cml_data && !status_clr_in) || bad_set;
    end
  end

  // Alert line, asserted while any flag stands
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alert_n_out <= 1'b1;
    end else begin
      alert_n_out <= !(ov_s || ovw_hit || uvw_hit || bad_set
                       || (|st_q && !status_clr_in));
    end
  end

  assign status_out = st_q;
  assign ovw_pct_out = ovw_pct_q;
  assign uvw_pct_out = uvw_pct_q;
  assign restart_cnt_out = cnt_q;

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [18:0] hic_len_q;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hic_len_q <= 19'h00000;
    end else begin
      hic_len_q <= (state_q == vocr_pkg::ST_BACKOFF) ? hic_len_q + 19'h00001 : 19'h00000;
    end
  end

  sequence s_shutdown;
    state_q == vocr_pkg::ST_ON && en_s && ov_s && act != `VOCR_ACT_IGNORE;
  endsequence

  a_ov_flags_set: assert property (ov_s |=> st_q.vout_ovf && st_q.byte_ov
    && st_q.word_vout && !alert_n_out)
    else $error("ov fault flags not set");
  a_ignore_stays_on: assert property (state_q == vocr_pkg::ST_ON && en_s && ov_s
    && act == `VOCR_ACT_IGNORE |=> state_q == vocr_pkg::ST_ON && conv_on_out)
    else $error("ignore action shut down");
  a_no_retry_latch: assert property (s_shutdown and retry == 3'h0
    |=> state_q == vocr_pkg::ST_LATCH)
    else $error("retry zero did not latch");
  a_retry_limit: assert property (s_shutdown and attempt_q && retry != 3'h7
    && retry != 3'h0 && cnt_q + 3'h1 == retry |=> state_q == vocr_pkg::ST_LATCH)
    else $error("retry limit not honoured");
  a_forever_retry: assert property (s_shutdown and retry == 3'h7
    |=> state_q == vocr_pkg::ST_BACKOFF && !conv_on_out)
    else $error("unlimited retry latched");
  a_backoff_len: assert property (state_q == vocr_pkg::ST_BACKOFF
    && state_d == vocr_pkg::ST_ON |-> hic_len_q == 19'(ton_rise_ticks_in) * 19'(mult)
    - 19'h00001 || ton_rise_ticks_in == 16'h0000)
    else $error("backoff period wrong");
  a_success_clear: assert property (win_end && en_s |=> cnt_q == 3'h0 && !attempt_q)
    else $error("success did not clear counter");
  a_ov_blocks_start: assert property (state_q != vocr_pkg::ST_ON && ov_s
    |=> !conv_on_out)
    else $error("started into ov fault");
  a_bad_data_flag: assert property (bad_set |=> st_q.cml_data && !alert_n_out)
    else $error("invalid data not flagged");
  a_warn_high_flag: assert property (ovw_hit |=> st_q.high_warn_limit_field && st_q.word_vout)
    else $error("ov warning not flagged");
  a_off_clears_cnt: assert property (!en_s |=> cnt_q == 3'h0 && !attempt_q)
    else $error("counter kept while off");
endmodule

// ### verification/vocr_host.sv
`timescale 1ns/1ps
// Host controller on the far side of the command link
module vocr_host (
  // Link clock and request
  output logic lnk_clk_out,
  output logic lnk_req_out,
  output vocr_pkg::vocr_cmd_s lnk_cmd_out,
  // Answer from the device
  input wire logic lnk_busy_in,
  input wire logic lnk_rsp_valid_in,
  input wire logic [15:0] lnk_rdata_in
);
  logic run = 1'b1;

  // Clock runs through reset, then only inside transfers
  initial begin
    lnk_clk_out = 1'b0;
    lnk_req_out = 1'b0;
    lnk_cmd_out = '0;
    #300 run = 1'b0;
  end

  // Stops low so no stray edge reaches the device
  always #32 if (run || lnk_clk_out) lnk_clk_out = ~lnk_clk_out;

  // One transfer; read data stays unknown if no answer comes
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
                      input logic [15:0] data, output logic [15:0] rdata);
    int n;
    n = 0;
    rdata = 16'hXXXX;
    run = 1'b1;
    @(negedge lnk_clk_out);
    while (lnk_busy_in === 1'b1) @(negedge lnk_clk_out);
    lnk_cmd_out = '{write: wr, word: wd, code: code, data: data};
    lnk_req_out = 1'b1;
    @(negedge lnk_clk_out);
    lnk_req_out = 1'b0;
    lnk_cmd_out = ~lnk_cmd_out;
    while (lnk_rsp_valid_in !== 1'b1 && n < 40) begin
      @(negedge lnk_clk_out);
      n++;
    end
    if (n < 40) rdata = lnk_rdata_in;
    run = 1'b0;
  endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "vocr_cfg.svh"
module testbench;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic lnk_clk_in, lnk_req_in, lnk_busy_out, lnk_rsp_valid_out;
  vocr_pkg::vocr_cmd_s lnk_cmd_in;
  logic [15:0] lnk_rdata_out;
  logic [15:0] vout_sense_in = 16'h04B0;
  logic [15:0] vout_cmd_in = 16'h04B0;
  logic ov_fault_in = 1'b0;
  logic enable_in = 1'b0;
  logic vout_rel_in = 1'b1;
  logic status_clr_in = 1'b0;
  logic rise_done_in = 1'b0;
  logic ton_max_on_in = 1'b0;
  logic ton_max_done_in = 1'b0;
  logic conv_on_out, alert_n_out;
  vocr_pkg::vocr_status_s status_out;
  logic [7:0] ovw_pct_out, uvw_pct_out;
  logic [2:0] restart_cnt_out;
  int err_total = 0;
  int n_checks = 0;
  logic [15:0] tv_lim [6] = '{16'h0211, 16'h0251, 16'h0252, 16'h01F1, 16'h01AE, 16'h01AF};
  logic [7:0] bc [4] = '{8'h41, 8'h41, 8'h44, 8'h42};
  logic bw [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [15:0] bd [4] = '{16'h0008, 16'h00C5, 16'h0000, 16'h0234};

  // Core clock
  always #50 core_clk_in = ~core_clk_in;

  vocr_core dut (.core_clk_in(core_clk_in), .lnk_clk_in(lnk_clk_in), .rst_n_in(rst_n_in),
    .lnk_req_in(lnk_req_in), .lnk_cmd_in(lnk_cmd_in), .lnk_busy_out(lnk_busy_out),
    .lnk_rsp_valid_out(lnk_rsp_valid_out), .lnk_rdata_out(lnk_rdata_out),
    .ov_fault_in(ov_fault_in), .enable_in(enable_in), .vout_sense_in(vout_sense_in),
    .vout_cmd_in(vout_cmd_in), .vout_rel_in(vout_rel_in), .ton_rise_ticks_in(16'h0004),
    .ton_max_on_in(ton_max_on_in), .rise_done_in(rise_done_in),
    .ton_max_done_in(ton_max_done_in),
    .conv_on_out(conv_on_out), .status_clr_in(status_clr_in), .status_out(status_out),
    .alert_n_out(alert_n_out), .ovw_pct_out(ovw_pct_out), .uvw_pct_out(uvw_pct_out),
    .restart_cnt_out(restart_cnt_out));

  vocr_host host (.lnk_clk_out(lnk_clk_in), .lnk_req_out(lnk_req_in), .lnk_cmd_out(lnk_cmd_in),
    .lnk_busy_in(lnk_busy_out), .lnk_rsp_valid_in(lnk_rsp_valid_out),
    .lnk_rdata_in(lnk_rdata_out));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  // Bounded wait for the power stage enable
  task automatic wait_on(input logic v, output int n);
    n = 0;
    while (conv_on_out !== v && n < 200) begin
      @(negedge core_clk_in);
      n++;
    end
  endtask

  task automatic clr;
    status_clr_in = 1'b1;
    cyc(1);
    status_clr_in = 1'b0;
    cyc(2);
  endtask

  // Window start on one source, then the counter once the window is over
  task automatic pulse_win(input logic rise, input logic [15:0] e);
    rise_done_in = rise;
    ton_max_done_in = !rise;
    cyc(1);
    rise_done_in = 1'b0;
    ton_max_done_in = 1'b0;
    cyc(7);
    chk({13'h0000, restart_cnt_out}, e, "window end");
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    host.xfer(1'b1, c != `VOCR_CMD_OV_RESP, c, d, r);
    cyc(3);
    chk(r, 16'h0000, "write answer");
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] r;
    host.xfer(1'b0, c != `VOCR_CMD_OV_RESP, c, 16'h0000, r);
    cyc(3);
    chk(r, e, "read data");
    chk({15'h0000, lnk_busy_out}, 16'h0000, "busy after answer");
  endtask

  // Repeated OV faults under one response setting
  task automatic faults(input logic [7:0] resp, input int nf);
    int n, lb;
    wr(`VOCR_CMD_OV_RESP, {8'h00, resp});
    lb = 4 * (resp[2:0] == 3'h0 ? 1 : int'(resp[2:0]));
    enable_in = 1'b1;
    wait_on(1'b1, n);
    for (int i = 0; i < nf; i++) begin
      ov_fault_in = 1'b1;
      cyc(3);
      ov_fault_in = 1'b0;
      wait_on(1'b0, n);
      chk({alert_n_out, 9'h000, status_out}, 16'h0038, "ov flags");
      chk({13'h0000, restart_cnt_out}, 16'(i), "restart count");
      // Let the synced fault fall before clearing, or the set wins
      cyc(2);
      clr();
      chk({alert_n_out, 9'h000, status_out}, 16'h8000, "flags cleared");
      wait_on(1'b1, n);
      if (resp[5:3] == 3'h7 || i < resp[5:3]) begin
        chk(16'(n + 5 >= lb - 1 && n + 5 <= lb + 1), 16'h0001, "backoff");
      end else begin
        chk({15'h0000, conv_on_out}, 16'h0000, "latched off");
      end
    end
  endtask

  task automatic results;
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [15:0] prev [2];
    logic [15:0] r;
    logic [7:0] pv [2];
    int p, k, n;
    logic ok;
    cyc(2);
    rst_n_in = 1'b1;
    cyc(10);
    chk({ovw_pct_out, uvw_pct_out}, 16'h6F5A, "pct reset");
    chk({alert_n_out, 9'h000, status_out}, 16'h8000, "status reset");
    rd(`VOCR_CMD_OV_RESP, {8'h00, `VOCR_OV_RESP_RST});
    rd(`VOCR_CMD_OV_WARN, `VOCR_OV_WARN_RST);
    rd(`VOCR_CMD_UV_WARN, `VOCR_UV_WARN_RST);
    // Relative limits in both windows, across the OV upper and UV lower edges
    prev[0] = `VOCR_OV_WARN_RST;
    prev[1] = `VOCR_UV_WARN_RST;
    pv[0] = 8'h6F;
    pv[1] = 8'h5A;
    for (int i = 0; i < 6; i++) begin
      k = i / 3;
      p = k ? int'(tv_lim[i]) * 100 / 512 : (int'(tv_lim[i]) * 100 + 511) / 512;
      ok = k ? (p >= 84 && p <= 97) : (p >= 103 && p <= 116);
      if (ok) prev[k] = tv_lim[i];
      if (ok) pv[k] = 8'(p);
      wr(8'(8'h42 + k), tv_lim[i]);
      rd(8'(8'h42 + k), prev[k]);
      chk({8'h00, k ? uvw_pct_out : ovw_pct_out}, {8'h00, pv[k]}, "pct");
      chk({15'h0000, status_out.cml_data}, {15'h0000, !ok}, "range");
      clr();
    end
    // Absolute limits survive a change of target
    vout_rel_in = 1'b0;
    vout_cmd_in = 16'h03E8;
    wr(`VOCR_CMD_OV_WARN, 16'h0438);
    wr(`VOCR_CMD_UV_WARN, 16'h0393);
    vout_cmd_in = 16'h04B0;
    rd(`VOCR_CMD_OV_WARN, 16'h0438);
    rd(`VOCR_CMD_UV_WARN, 16'h0393);
    chk({ovw_pct_out, uvw_pct_out}, 16'h6C5B, "abs pct");
    // Warnings against the live target
    enable_in = 1'b1;
    wait_on(1'b1, n);
    clr();
    vout_sense_in = 16'h0514;
    cyc(3);
    chk({alert_n_out, 9'h000, status_out}, 16'h0014, "ov warning");
    vout_sense_in = 16'h03E8;
    cyc(3);
    chk({alert_n_out, 9'h000, status_out}, 16'h0016, "uv warning");
    vout_sense_in = 16'h04B0;
    clr();
    enable_in = 1'b0;
    cyc(4);
    // Refused writes leave contents alone
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, bw[i], bc[i], bd[i], r);
      cyc(3);
      chk(r, 16'h0000, "refused answer");
      chk({alert_n_out, 9'h000, status_out}, 16'h0001, "bad data");
      clr();
    end
    rd(`VOCR_CMD_OV_RESP, 16'h0080);
    // Restart policies
    faults(8'h80, 1);
    enable_in = 1'b0;
    cyc(4);
    faults(8'h53, 3);
    enable_in = 1'b0;
    cyc(4);
    chk({13'h0000, restart_cnt_out}, 16'h0000, "off clears count");
    faults(8'hB8, 4);
    rise_done_in = 1'b1;
    cyc(1);
    rise_done_in = 1'b0;
    cyc(1);
    chk({13'h0000, restart_cnt_out}, 16'h0003, "window open");
    cyc(6);
    chk({13'h0000, restart_cnt_out}, 16'h0000, "start success");
    // Nonzero start limit: window opens on its own pulse only
    faults(8'hB8, 2);
    ton_max_on_in = 1'b1;
    pulse_win(1'b1, 16'h0001);
    pulse_win(1'b0, 16'h0000);
    enable_in = 1'b0;
    cyc(4);
    // Ignore setting still refuses to start into a fault
    wr(`VOCR_CMD_OV_RESP, 16'h0000);
    ov_fault_in = 1'b1;
    cyc(3);
    enable_in = 1'b1;
    cyc(10);
    chk({15'h0000, conv_on_out}, 16'h0000, "start blocked");
    ov_fault_in = 1'b0;
    wait_on(1'b1, n);
    ov_fault_in = 1'b1;
    cyc(6);
    chk({15'h0000, conv_on_out}, 16'h0001, "fault ignored");
    ov_fault_in = 1'b0;
    results();
  end

  // Cut a hang short
  initial begin
    #3_000_000;
    err_total++;
    results();
  end
endmodule
